// *** arc_consts.svh ***
/*
  Constants for the converter result coding block: register addresses, field
  positions, reset values and code limits.
  Assumes it is included by bare name from files that need these values.
*/
`ifndef ARC_CONSTS_SVH
`define ARC_CONSTS_SVH

// Status result addresses on the register access port.
`define ARC_ADDR_TEMPERATURE   7'h00
`define ARC_ADDR_CORE_SUPPLY   7'h01
`define ARC_ADDR_AUX_SUPPLY    7'h02
`define ARC_ADDR_BLOCKRAM      7'h06
`define ARC_ADDR_EXTRA_A       7'h0d
`define ARC_ADDR_EXTRA_B       7'h0e
`define ARC_ADDR_EXTRA_C       7'h0f
// Control register window: thirty-two words from 40h.
`define ARC_ADDR_CTRL_BASE     7'h40
`define ARC_CTRL_COUNT         32
// Control register 0 fields of our choosing: bipolar select bit.
`define ARC_CTRL0_BIPOLAR_BIT  10
// Result word layout: 12-bit code sits in bits 15..4.
`define ARC_CODE_LSB           4
`define ARC_CODE_WIDTH         12
// Reset value of a status register; control registers reset to PRESETS, not ARC_CTRL_RESET.
`define ARC_STATUS_RESET       16'h0000
`define ARC_CTRL_RESET         16'h0000
// Code limits.
`define ARC_UNI_MIN            12'h000
`define ARC_UNI_MAX            12'hfff
`define ARC_BIP_MAX            12'h7ff
`define ARC_BIP_MIN            12'h800

`endif

// *** arc_pkg.sv ***
/*
  Types for the converter result coding block.
  Assumes arc_consts.svh is available to the design files.
*/
package arc_pkg;

  // Source of a finished conversion.
  typedef enum logic [2:0] {
    ARC_SRC_TEMPERATURE,
    ARC_SRC_CORE,
    ARC_SRC_AUX,
    ARC_SRC_BLOCKRAM,
    ARC_SRC_EXTRA_A,
    ARC_SRC_EXTRA_B,
    ARC_SRC_EXTRA_C,
    ARC_SRC_EXTERNAL
  } arc_src_t;

  // One raw measurement from a converter.
  typedef struct packed {
    arc_src_t     src;     // Which input was measured.
    logic [15:0]  raw;     // Unsigned 16-bit sample, 0 = lowest input.
  } arc_sample_t;

  // Register access port request.
  typedef struct packed {
    logic         en;      // Access strobe.
    logic         we;      // Write when high.
    logic [6:0]   addr;    // Register address.
    logic [15:0]  wdata;   // Write data.
  } arc_req_t;

  // Port state.
  typedef enum logic [1:0] {
    ARC_PORT_IDLE,
    ARC_PORT_WAIT,
    ARC_PORT_DONE
  } arc_port_state_t;

endpackage

// *** arc_coder.sv ***
/*
  Result coder: turns one raw 16-bit sample into the stored 16-bit word,
  straight binary or two's complement, code left-justified.
  Assumes raw samples are unsigned with mid-scale meaning zero difference.
*/
`timescale 1ns/10ps
`include "arc_consts.svh"

module arc_coder
(
  // Sample in.
  input  wire arc_pkg::arc_sample_t sample,
  input  wire logic                 bipolar_cfg,
  // Coded word out.
  output logic [15:0]               coded
);

  logic use_bipolar;   // Coding actually applied to this sample.

  // Sensors always use straight binary; only external inputs may be signed.
  always_comb
  begin
    use_bipolar = bipolar_cfg && (sample.src == arc_pkg::ARC_SRC_EXTERNAL);
    if (use_bipolar)
    begin
      // Flipping the MSB maps offset binary to two's complement:
      // top input gives 7FFh, bottom gives 800h.
      coded = {~sample.raw[15], sample.raw[14:0]};
    end
    else
    begin
      // Straight binary, 000h at bottom, FFFh at full scale. Sensor scaling
      // (1 V or 3 V full scale) is set by the analog front end, so the code
      // path is identical for both.
      coded = sample.raw;
    end
  end

endmodule

// *** arc_result_block.sv ***
/*
  Result placement and register access port for a dual converter.
  Holds status result words and thirty-two control words, and answers the
  fabric through a synchronous port with a ready strobe.
  Assumes samples and port requests are synchronous to clk.
*/
//
// Overview of operation
// - Control words preset, or written via port.
// - Two independent converters with 12-bit results.
// - Unipolar: 000h at zero, FFFh full.
// - Unipolar coding is straight binary.
// - External inputs unipolar unless bipolar configured.
// - Bipolar: two's complement, 7FFh to 800h.
// - Sensors always converted unipolar.
// - Result stored as 16 bits, code high.
// - Temperature result goes to status 00h.
// - Supply sensors scaled to 3 V full scale.
// - Core, aux, blockram supplies to 01h,02h,06h.
// - Extra supplies to 0Dh, 0Eh, 0Fh.
// - Done pulses when result is written.
// - Thirty-two 16-bit control registers, preset by address.
`timescale 1ns/10ps
`include "arc_consts.svh"

module arc_result_block
#(
  parameter int                 N_CONV  = 2,   // Independent converters.
  parameter logic [16*32-1:0]   PRESETS = '0,  // Configuration-time presets, word i at 40h+i.
  parameter bit                 HAS_EXTRA = 1'b1 // Processor variant with extra supplies.
)
(
  // Clock, reset and enable.
  input  wire logic                              clk,
  input  wire logic                              nrst,
  input  wire logic                              ce,
  // Converter results, one per converter.
  input  wire logic [N_CONV-1:0]                 sample_valid,
  input  wire arc_pkg::arc_sample_t [N_CONV-1:0] sample_in,
  // Register access port.
  input  wire arc_pkg::arc_req_t                 req,
  output logic [15:0]                            port_rdata,
  output logic                                   port_ready_out,
  // Conversion status.
  output logic                                   conv_done,
  output logic [15:0]                            ext_result,
  output logic                                   bipolar_mode
);

  // Refuse converter counts that the result slots and decoding cannot serve.
  if (N_CONV < 1 || N_CONV > 2)
  begin : g_bad_n_conv
    $error("N_CONV must be 1 or 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [15:0] status_reg [0:15];          // Status results, indexed by address.
  logic [15:0] ctrl_reg   [0:`ARC_CTRL_COUNT-1]; // Control words.
  logic [15:0] coded      [N_CONV];        // Coded word per converter.
  logic [3:0]  dest       [N_CONV];        // Status index per converter.
  logic        dest_ok    [N_CONV];        // Destination exists.
  arc_pkg::arc_port_state_t state;         // Port state.
  logic [6:0]  lat_addr;                   // Address held for the answer.

  assign bipolar_mode = ctrl_reg[0][`ARC_CTRL0_BIPOLAR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Coding and destination, one per converter.

  genvar g;
  generate
    for (g = 0; g < N_CONV; g++)
    begin : g_conv
      // Each converter has its own coder, so both run independently.
      arc_coder u_coder
      (
        .sample      (sample_in[g]),
        .bipolar_cfg (bipolar_mode),
        .coded       (coded[g])
      );

      // Steer each sensor to its fixed status address.
      always_comb
      begin
        dest_ok[g] = 1'b1;
        case (sample_in[g].src)
          arc_pkg::ARC_SRC_TEMPERATURE: dest[g] = 4'(`ARC_ADDR_TEMPERATURE);
          arc_pkg::ARC_SRC_CORE:        dest[g] = 4'(`ARC_ADDR_CORE_SUPPLY);
          arc_pkg::ARC_SRC_AUX:         dest[g] = 4'(`ARC_ADDR_AUX_SUPPLY);
          arc_pkg::ARC_SRC_BLOCKRAM:    dest[g] = 4'(`ARC_ADDR_BLOCKRAM);
          arc_pkg::ARC_SRC_EXTRA_A:
          begin
            dest[g]    = 4'(`ARC_ADDR_EXTRA_A);
            dest_ok[g] = HAS_EXTRA;
          end
          arc_pkg::ARC_SRC_EXTRA_B:
          begin
            dest[g]    = 4'(`ARC_ADDR_EXTRA_B);
            dest_ok[g] = HAS_EXTRA;
          end
          arc_pkg::ARC_SRC_EXTRA_C:
          begin
            dest[g]    = 4'(`ARC_ADDR_EXTRA_C);
            dest_ok[g] = HAS_EXTRA;
          end
          default:
          begin
            // External channels go to the result output, not a sensor slot.
            dest[g]    = 4'h0;
            dest_ok[g] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Status registers: written only by converters, never by the port.

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 16; i++)
        status_reg[i] <= `ARC_STATUS_RESET;
    end
    else if (ce)
    begin
      // Converter 1 wins when both target the same slot.
      for (int c = 0; c < N_CONV; c++)
        if (sample_valid[c] && dest_ok[c])
          status_reg[dest[c]] <= coded[c];
    end
  end

  // External channel result and done strobe, written in the same cycle.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_result <= `ARC_STATUS_RESET;
      conv_done  <= 1'b0;
    end
    else if (ce)
    begin
      conv_done <= |sample_valid;
      for (int c = 0; c < N_CONV; c++)
        if (sample_valid[c] && sample_in[c].src == arc_pkg::ARC_SRC_EXTERNAL)
          ext_result <= coded[c];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers: presets at reset, then writable through the port.

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < `ARC_CTRL_COUNT; i++)
        ctrl_reg[i] <= PRESETS[16*i +: 16];
    end
    else if (ce && state == arc_pkg::ARC_PORT_IDLE && req.en && req.we
             && req.addr[6] == 1'b1 && req.addr[5] == 1'b0)
    begin
      ctrl_reg[req.addr[4:0]] <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port sequencing: take request, wait one cycle, answer with ready.

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state    <= arc_pkg::ARC_PORT_IDLE;
      lat_addr <= 7'h00;
    end
    else if (ce)
    begin
      case (state)
        arc_pkg::ARC_PORT_IDLE:
        begin
          // Requests arriving while busy are ignored.
          if (req.en)
          begin
            lat_addr <= req.addr;
            state    <= arc_pkg::ARC_PORT_WAIT;
          end
        end
        arc_pkg::ARC_PORT_WAIT: state <= arc_pkg::ARC_PORT_DONE;
        arc_pkg::ARC_PORT_DONE: state <= arc_pkg::ARC_PORT_IDLE;
        default:                state <= arc_pkg::ARC_PORT_IDLE;
      endcase
    end
  end

  // Read data captured the cycle before ready, so data and ready align.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      port_rdata <= 16'h0000;
    else if (ce && state == arc_pkg::ARC_PORT_WAIT)
    begin
      if (lat_addr[6:4] == 3'h0)
        port_rdata <= status_reg[lat_addr[3:0]];
      else if (lat_addr[6:5] == 2'b10)
        port_rdata <= ctrl_reg[lat_addr[4:0]];
      else
        port_rdata <= 16'h0000;  // Unmapped addresses read zero.
    end
  end

  // Data is valid only while ready is high.
  assign port_ready_out = (state == arc_pkg::ARC_PORT_DONE);

endmodule

// *** arc_result_block_asserts.sv ***
/*
  Checker for the result block: port answer timing, done flag and coding.
  Assumes it is bound to arc_result_block; samples taken while ce is low
  are frozen out, so a_done_follows and the mode checks only count enabled cycles.
*/
`timescale 1ns/10ps
module arc_rb_checker
#(
  parameter int N_CONV = 2 // Number of converters.
)
(
  // Clock and reset.
  input wire logic                              clk,
  input wire logic                              nrst,
  input wire logic                              ce,
  // Converter side.
  input wire logic [N_CONV-1:0]                 sample_valid,
  input wire arc_pkg::arc_sample_t [N_CONV-1:0] sample_in,
  // Port and status side.
  input wire arc_pkg::arc_req_t                 req,
  input wire logic [15:0]                       port_rdata,
  input wire logic                              port_ready_out,
  input wire logic                              conv_done,
  input wire logic [15:0]                       ext_result,
  input wire logic                              bipolar_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // A lone external sample on converter 0, so converter 1 cannot override it.
  wire ext0 = sample_valid[0] && !sample_valid[N_CONV-1] && sample_in[0].src == arc_pkg::ARC_SRC_EXTERNAL;
  a_ready_after_req: assert property (ce && req.en |-> ##2 port_ready_out)
    else $error("ready late");
  a_ready_one_cycle: assert property (port_ready_out |=> !port_ready_out)
    else $error("ready too long");
  a_ready_has_cause: assert property (port_ready_out |-> $past(req.en, 2))
    else $error("ready without request");
  a_rdata_holds: assert property (!port_ready_out |-> $stable(port_rdata))
    else $error("read data moved");
  a_done_follows: assert property (ce && |sample_valid |=> conv_done)
    else $error("done missing");
  a_done_has_cause: assert property (conv_done |-> $past(|sample_valid))
    else $error("done without sample");
  a_ext_unipolar: assert property (ce && ext0 && !bipolar_mode |=> ext_result == $past(sample_in[0].raw))
    else $error("unipolar code wrong");
  a_ext_bipolar: assert property (ce && ext0 && bipolar_mode |=>
    ext_result == {~$past(sample_in[0].raw[15]), $past(sample_in[0].raw[14:0])})
    else $error("bipolar code wrong");
  a_mode_write: assert property (ce && req.en && req.we && req.addr == 7'h40 |=>
    bipolar_mode == $past(req.wdata[10]))
    else $error("mode bit not stored");
  c_read: cover property (port_ready_out && !$past(req.we, 2));
  c_ext_bip: cover property (ext0 && bipolar_mode);
  c_done: cover property (conv_done);
endmodule
bind arc_result_block arc_rb_checker #(.N_CONV(N_CONV)) arc_rb_checker_inst (.clk(clk), .nrst(nrst), .ce(ce),
  .sample_valid(sample_valid), .sample_in(sample_in), .req(req), .port_rdata(port_rdata),
  .port_ready_out(port_ready_out), .conv_done(conv_done), .ext_result(ext_result), .bipolar_mode(bipolar_mode));

// *** arc_fabric_model.sv ***
/*
  Fabric requester model: issues one register access at a time.
  Assumes the bench calls access and drives at falling edges.
*/
`timescale 1ns/10ps
module arc_fabric_model
(
  // Clock.
  input wire logic          clk,
  // Request out, answer in.
  output arc_pkg::arc_req_t req,
  input wire logic [15:0]   port_rdata,
  input wire logic          port_ready_out
);
  initial req = '0;
  // Strobe for one cycle, then trust nothing until ready is seen.
  task automatic access(input logic we, input logic [6:0] a, input logic [15:0] wd, output logic [15:0] rd);
    int n;
    n = 0;
    rd = 'x;
    @(negedge clk);
    req = '{en:1'b1, we:we, addr:a, wdata:wd};
    @(negedge clk);
    // Released lines show junk so a stale value cannot pass.
    req = '{en:1'b0, we:~we, addr:~a, wdata:~wd};
    while (n < 8)
    begin
      if (port_ready_out === 1'b1)
      begin
        rd = port_rdata;
        n = 8;
      end
      else
      begin
        @(negedge clk);
        n++;
      end
    end
  endtask
endmodule

// *** tb_top.sv ***
/*
  Bench for the result block: register reads and writes plus samples.
  Assumes the fabric model and the bound checker are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  logic                        clk = 1'b0;
  logic                        nrst = 1'b0;
  logic                        ce = 1'b1;
  logic [1:0]                  sv = 2'h0;
  arc_pkg::arc_sample_t [1:0]  si = '0;
  arc_pkg::arc_req_t           req;
  logic [15:0]                 rdata, ext, v, d;
  logic                        rdy, done, bip;
  int                          num_errors = 0, check_count = 0, i;
  localparam logic [16*32-1:0] PRE = {16'h5a5a, {30{16'h0000}}, 16'h1234};
  localparam logic [6:0]       ADR [7] = '{7'h00, 7'h01, 7'h02, 7'h06, 7'h0d, 7'h0e, 7'h0f};
  always #12.5 clk = ~clk;
  arc_result_block #(.PRESETS(PRE)) arc_result_block_inst (.clk(clk), .nrst(nrst), .ce(ce),
    .sample_valid(sv), .sample_in(si), .req(req), .port_rdata(rdata), .port_ready_out(rdy),
    .conv_done(done), .ext_result(ext), .bipolar_mode(bip));
  arc_fabric_model arc_fabric_model_inst (.clk(clk), .req(req), .port_rdata(rdata), .port_ready_out(rdy));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    arc_fabric_model_inst.access(1'b0, a, 16'h0000, d);
    chk(d, exp);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] wd);
    arc_fabric_model_inst.access(1'b1, a, wd, d);
    chk({15'h0, $isunknown(d)}, 16'h0000);
  endtask
  // One-cycle sample pulse; the lines show junk afterwards.
  task automatic samp(input int c, input arc_pkg::arc_src_t s, input logic [15:0] r);
    @(negedge clk);
    sv[c] = 1'b1;
    si[c] = '{src:s, raw:r};
    @(negedge clk);
    chk({15'h0, done}, {15'h0, ce});
    sv = 2'h0;
    si[c].raw = ~r;
  endtask
  task automatic end_sim;
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #100us;
    num_errors++;
    end_sim;
  end
  initial
  begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    chk({15'h0, bip}, 16'h0000);
    rd(7'h40, 16'h1234);
    rd(7'h5f, 16'h5a5a);
    rd(7'h00, 16'h0000);
    wr(7'h5f, 16'hc3c3);
    rd(7'h5f, 16'hc3c3);
    wr(7'h40, 16'h0400);
    chk({15'h0, bip}, 16'h0001);
    // Sensors stay straight binary even with bipolar selected.
    for (i = 0; i < 7; i++)
    begin
      v = 16'hfff0 - 16'(i) * 16'h0110;
      samp(i % 2, arc_pkg::arc_src_t'(i), v);
      rd(ADR[i], v);
    end
    // Frozen clock enable: a sample must leave no trace and no done strobe.
    @(negedge clk);
    ce = 1'b0;
    samp(0, arc_pkg::ARC_SRC_TEMPERATURE, 16'h1230);
    ce = 1'b1;
    rd(7'h00, 16'hfff0);
    // A consumer turns code 977h into 25 degrees.
    samp(0, arc_pkg::ARC_SRC_TEMPERATURE, 16'h9770);
    rd(7'h00, 16'h9770);
    chk(16'($rtoi(real'(d[15:4]) * 503.975 / 4096.0 - 273.15 + 0.5)), 16'h0019);
    wr(7'h01, 16'h1111);
    rd(7'h01, 16'hfee0);
    rd(7'h10, 16'h0000);
    samp(1, arc_pkg::ARC_SRC_EXTERNAL, 16'hfff0);
    chk(ext, 16'h7ff0);
    samp(0, arc_pkg::ARC_SRC_EXTERNAL, 16'h0000);
    chk(ext, 16'h8000);
    wr(7'h40, 16'h0000);
    samp(1, arc_pkg::ARC_SRC_EXTERNAL, 16'hfff0);
    chk(ext, 16'hfff0);
    samp(0, arc_pkg::ARC_SRC_EXTERNAL, 16'h3330);
    chk(ext, 16'h3330);
    end_sim;
  end
endmodule
